// File: core/fruop_alu.sv
// package of constants and the unary arithmetic unit for file-register ops
`timescale 1ns/10ps
package fruop_pkg;
    localparam int FRUOP_DATA_W = 8;
    localparam int FRUOP_IDX_W = 5;
    localparam int FRUOP_INSTR_W = 12;
    localparam int FRUOP_NREGS = 32;
    // opcode field is instr[11:6], dest bit instr[5], index instr[4:0]
    localparam int FRUOP_OPC_MSB = 11;
    localparam int FRUOP_OPC_LSB = 6;
    localparam int FRUOP_DEST_BIT = 5;
    localparam logic [5:0] FRUOP_OPC_COMP = 6'h09;
    localparam logic [5:0] FRUOP_OPC_DEC = 6'h03;
    localparam logic [5:0] FRUOP_OPC_DSZ = 6'h0B;
    localparam logic FRUOP_DEST_W = 1'h0;
    localparam logic FRUOP_DEST_F = 1'h1;
    localparam logic [7:0] FRUOP_RST_DATA = 8'h00;
    localparam logic [7:0] FRUOP_ONE = 8'h01;
    localparam logic FRUOP_RST_Z = 1'h0;
    typedef enum logic [1:0]
    {
        FRUOP_OP_NONE = 2'b00,
        FRUOP_OP_COMP = 2'b01,
        FRUOP_OP_DEC = 2'b10,
        FRUOP_OP_DSZ = 2'b11
    } fruop_op_t;
    typedef enum logic [0:0]
    {
        FRUOP_ST_EXEC = 1'b0,
        FRUOP_ST_SKIP = 1'b1
    } fruop_state_t;
endpackage

module fruop_alu
(
    // operation select
    input wire fruop_pkg::fruop_op_t op,
    // operand from the selected file register
    input wire logic [7:0] operand,
    // result and its zero test
    output logic [7:0] result,
    output logic result_zero
);
    always_comb
    begin
        case (op)
            fruop_pkg::FRUOP_OP_COMP: result = ~operand;
            fruop_pkg::FRUOP_OP_DEC: result = operand - fruop_pkg::FRUOP_ONE;
            fruop_pkg::FRUOP_OP_DSZ: result = operand - fruop_pkg::FRUOP_ONE;
            default: result = operand;
        endcase
        result_zero = (result == fruop_pkg::FRUOP_RST_DATA);
    end
endmodule // fruop_alu

// File: core/fruop_core.sv
// decode and execute of complement, decrement and decrement-skip-zero
`timescale 1ns/10ps
module fruop_core
(
    // clock and synchronous reset
    input wire logic core_clk,
    input wire logic rst_n,
    // instruction stream, one word per instruction cycle
    input wire logic instr_valid,
    input wire logic [11:0] instr,
    // file register preload
    input wire logic load_en,
    input wire logic [4:0] load_addr,
    input wire logic [7:0] load_data,
    // file register peek
    input wire logic [4:0] peek_addr,
    output logic [7:0] peek_data,
    // architectural state
    output logic [7:0] work_reg,
    output logic zero_flag,
    // execution status
    output logic instr_done,
    output logic nop_exec,
    output logic skip_pending
);
    logic [7:0] file_mem [0:31];
    fruop_pkg::fruop_state_t state;
    fruop_pkg::fruop_state_t next_state;
    fruop_pkg::fruop_op_t op;
    logic dest;
    logic [4:0] idx;
    logic [7:0] operand;
    logic [7:0] result;
    logic result_zero;
    logic exec;
    logic [7:0] next_work_reg;
    logic next_zero_flag;
    logic next_instr_done;
    logic next_nop_exec;
    logic file_we;
    logic [4:0] file_wa;
    logic [7:0] file_wd;

    function automatic fruop_pkg::fruop_op_t decode_op(input logic [11:0] word);
        logic [5:0] opc;
        opc = word[fruop_pkg::FRUOP_OPC_MSB:fruop_pkg::FRUOP_OPC_LSB];
        case (opc)
            fruop_pkg::FRUOP_OPC_COMP: decode_op = fruop_pkg::FRUOP_OP_COMP;
            fruop_pkg::FRUOP_OPC_DEC: decode_op = fruop_pkg::FRUOP_OP_DEC;
            fruop_pkg::FRUOP_OPC_DSZ: decode_op = fruop_pkg::FRUOP_OP_DSZ;
            default: decode_op = fruop_pkg::FRUOP_OP_NONE;
        endcase
    endfunction

    // full 5-bit index, all 32 entries exist so no range check needed
    assign op = decode_op(instr);
    assign dest = instr[fruop_pkg::FRUOP_DEST_BIT];
    assign idx = instr[4:0];
    assign operand = file_mem[idx];
    // a word arriving while the skip slot is open is the discarded one
    assign exec = instr_valid && (state == fruop_pkg::FRUOP_ST_EXEC);

    fruop_alu u_alu
    (
        .op(op),
        .operand(operand),
        .result(result),
        .result_zero(result_zero)
    );

    always_comb
    begin
        next_state = state;
        next_work_reg = work_reg;
        next_zero_flag = zero_flag;
        next_instr_done = 1'b0;
        next_nop_exec = 1'b0;
        file_we = 1'b0;
        file_wa = load_addr;
        file_wd = load_data;
        if (load_en)
        begin
            file_we = 1'b1;
        end
        case (state)
            fruop_pkg::FRUOP_ST_EXEC:
            begin
                if (exec && op != fruop_pkg::FRUOP_OP_NONE)
                begin
                    next_instr_done = 1'b1;
                    if (dest == fruop_pkg::FRUOP_DEST_W)
                    begin
                        next_work_reg = result;
                    end
                    else
                    begin
                        // execution write wins over a preload in the same cycle
                        file_we = 1'b1;
                        file_wa = idx;
                        file_wd = result;
                    end
                    if (op != fruop_pkg::FRUOP_OP_DSZ)
                    begin
                        next_zero_flag = result_zero;
                    end
                    else if (result_zero)
                    begin
                        next_state = fruop_pkg::FRUOP_ST_SKIP;
                    end
                end
            end
            fruop_pkg::FRUOP_ST_SKIP:
            begin
                if (instr_valid)
                begin
                    // fetched word dropped, nop takes its cycle
                    next_nop_exec = 1'b1;
                    next_state = fruop_pkg::FRUOP_ST_EXEC;
                end
            end
            default: next_state = fruop_pkg::FRUOP_ST_EXEC;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state <= fruop_pkg::FRUOP_ST_EXEC;
            work_reg <= fruop_pkg::FRUOP_RST_DATA;
            zero_flag <= fruop_pkg::FRUOP_RST_Z;
            instr_done <= 1'b0;
            nop_exec <= 1'b0;
            skip_pending <= 1'b0;
            peek_data <= fruop_pkg::FRUOP_RST_DATA;
        end
        else
        begin
            state <= next_state;
            work_reg <= next_work_reg;
            zero_flag <= next_zero_flag;
            instr_done <= next_instr_done;
            nop_exec <= next_nop_exec;
            skip_pending <= (next_state == fruop_pkg::FRUOP_ST_SKIP);
            peek_data <= file_mem[peek_addr];
        end
    end

    // memory not reset: file contents are undefined after reset like real ram
    always_ff @(posedge core_clk)
    begin
        if (file_we)
        begin
            file_mem[file_wa] <= file_wd;
        end
    end

    a_comp_to_w: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_COMP && dest == 1'b0 |=> work_reg == ~$past(operand))
        else $error("complement to W gave wrong value");
    a_comp_to_file: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_COMP && dest == 1'b1 && !load_en ##1 peek_addr == $past(idx)
        |=> peek_data == ~$past(operand, 2))
        else $error("complement to file wrote wrong value");
    a_dest_file_keeps_w: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op != fruop_pkg::FRUOP_OP_NONE && dest == 1'b1 |=> $stable(work_reg))
        else $error("file destination changed W");
    a_dest_file_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DEC && dest == 1'b1 && !load_en ##1 peek_addr == $past(idx)
        |=> peek_data == $past(operand, 2) - 8'h01)
        else $error("decrement to file wrote wrong value");
    a_dec_to_w: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DEC && dest == 1'b0 |=> work_reg == $past(operand) - 8'h01)
        else $error("decrement to W gave wrong value");
    a_dsz_value_w: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DSZ && dest == 1'b0 |=> work_reg == $past(operand) - 8'h01)
        else $error("decrement-skip to W gave wrong value");
    a_dsz_to_file: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DSZ && dest == 1'b1 && !load_en ##1 peek_addr == $past(idx)
        |=> peek_data == $past(operand, 2) - 8'h01)
        else $error("decrement-skip to file wrote wrong value");
    // the slot waits for the next valid word, so no fixed cycle count here
    a_skip_discard: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DSZ && operand == 8'h01 |=> skip_pending)
        else $error("zero result did not open the skip slot");
    a_skip_nop: assert property (@(posedge core_clk) disable iff (!rst_n)
        skip_pending && instr_valid |=> nop_exec && !instr_done && !skip_pending)
        else $error("next word not replaced by a nop");
    a_nop_keeps_state: assert property (@(posedge core_clk) disable iff (!rst_n)
        skip_pending && instr_valid |=> $stable(work_reg) && $stable(zero_flag))
        else $error("discarded word changed state");
    a_no_skip_nonzero: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DSZ && operand != 8'h01 |=> !skip_pending)
        else $error("skip taken on nonzero result");
    a_zero_update: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && (op == fruop_pkg::FRUOP_OP_COMP || op == fruop_pkg::FRUOP_OP_DEC)
        |=> instr_done && zero_flag == (($past(op) == fruop_pkg::FRUOP_OP_COMP) ?
            ($past(operand) == 8'hFF) : ($past(operand) == 8'h01)))
        else $error("zero flag not updated in one cycle");
    a_dsz_keeps_z: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DSZ |=> $stable(zero_flag))
        else $error("decrement-skip changed zero flag");
    a_high_index: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_COMP && idx == 5'h1F && dest == 1'b0 |=> work_reg == ~$past(file_mem[31]))
        else $error("top index not reached");

    c_skip_taken: cover property (@(posedge core_clk) disable iff (!rst_n) nop_exec);
    c_comp_file: cover property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_COMP && dest == 1'b1);
    c_dec_zero: cover property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DEC && result_zero);
    c_dec_wrap: cover property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_DEC && operand == 8'h00);
    c_high_index: cover property (@(posedge core_clk) disable iff (!rst_n)
        exec && op == fruop_pkg::FRUOP_OP_COMP && idx == 5'h1F && dest == 1'b0);
endmodule // fruop_core

// File: test/fruop_core_tb_top.sv
// self-checking bench for the file-register unary op core
`timescale 1ns/10ps
module fruop_core_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [11:0] instr = 12'h000;
    logic load_en = 1'b0;
    logic [4:0] load_addr = 5'h00;
    logic [7:0] load_data = 8'h00;
    logic [4:0] peek_addr = 5'h00;
    logic [7:0] peek_data;
    logic [7:0] work_reg;
    logic zero_flag;
    logic instr_done;
    logic nop_exec;
    logic skip_pending;
    int error_cnt = 0;
    int samples_checked = 0;
    always #50 core_clk = ~core_clk;
    fruop_core dut
    (
        .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .load_en(load_en), .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr),
        .peek_data(peek_data), .work_reg(work_reg), .zero_flag(zero_flag),
        .instr_done(instr_done), .nop_exec(nop_exec), .skip_pending(skip_pending)
    );
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task load(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        load_en <= 1'b1;
        load_addr <= a;
        load_data <= d;
        @(posedge core_clk);
        load_en <= 1'b0;
    endtask
    // file memory is only seen through the registered peek port
    task peek(input logic [4:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        peek_addr <= a;
        @(posedge core_clk);
        @(posedge core_clk);
        #1;
        chk(peek_data, exp);
    endtask
    // one word, then results checked just after the edge that takes it
    task issue(input logic [11:0] w, input logic [7:0] w_exp, input logic z_exp);
        @(posedge core_clk);
        instr <= w;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
        chk(work_reg, w_exp);
        chk({7'h00, zero_flag}, {7'h00, z_exp});
        chk({7'h00, instr_done}, 8'h01);
    endtask
    task test_comp;
        load(5'h03, 8'h13);
        issue(12'h243, 8'hEC, 1'b0);
        peek(5'h03, 8'h13);
        load(5'h1F, 8'hFF);
        peek_addr <= 5'h1F;
        issue(12'h27F, 8'hEC, 1'b1);
        peek(5'h1F, 8'h00);
        issue(12'h25F, 8'hFF, 1'b0);
    endtask
    task test_dec;
        load(5'h00, 8'h00);
        issue(12'h0C0, 8'hFF, 1'b0);
        peek_addr <= 5'h07;
        load(5'h07, 8'h01);
        issue(12'h0E7, 8'hFF, 1'b1);
        peek(5'h07, 8'h00);
    endtask
    // back to back: non-zero result keeps the next word, zero result drops it
    task test_skip;
        peek_addr <= 5'h05;
        load(5'h04, 8'h05);
        load(5'h05, 8'h01);
        @(posedge core_clk);
        instr <= 12'h2C4;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr <= 12'h244;
        #1;
        chk(work_reg, 8'h04);
        chk({7'h00, zero_flag, skip_pending}, 8'h02);
        @(posedge core_clk);
        instr <= 12'h2E5;
        #1;
        chk(work_reg, 8'hFA);
        chk({6'h00, zero_flag, instr_done}, 8'h01);
        @(posedge core_clk);
        instr <= 12'h244;
        #1;
        chk({5'h00, instr_done, skip_pending, zero_flag}, 8'h06);
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
        chk({5'h00, nop_exec, instr_done, skip_pending}, 8'h04);
        chk(work_reg, 8'hFA);
        peek(5'h05, 8'h00);
    endtask
    task close_out;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        test_comp;
        test_dec;
        test_skip;
        close_out;
    end
    // run needs about 44 cycles; allow 1000, over twenty times that
    initial
    begin
        #100000;
        error_cnt++;
        close_out;
    end
endmodule // fruop_core_tb_top
